// [hw/lmcd_pkg.sv]
// Package for the motor command decoder: codes, offsets, resets and carriers
package lmcd_pkg;
    // ==========================================================
    // Command codes
    localparam logic [6:0] CMD_READ_POS = 7'h00;
    localparam logic [6:0] CMD_READ_FULL = 7'h01;
    localparam logic [6:0] CMD_READ_FUSE = 7'h02;
    localparam logic [6:0] CMD_READ_BRIEF = 7'h03;
    localparam logic [6:0] CMD_GO_SAFE = 7'h04;
    localparam logic [6:0] CMD_HALT = 7'h05;
    localparam logic [6:0] CMD_ZERO = 7'h06;
    localparam logic [6:0] CMD_TWO_TARGET = 7'h08;
    localparam logic [6:0] CMD_MOTION_CFG = 7'h09;
    localparam logic [6:0] CMD_FUSE_PROG = 7'h10;
    localparam logic [6:0] CMD_STALL_CFG = 7'h16;
    localparam logic [6:0] CMD_ABS_MOVE = 7'h0b;
    localparam logic [6:0] CMD_SHORT_1 = 7'h0c;
    localparam logic [6:0] CMD_SHORT_2 = 7'h0d;
    localparam logic [6:0] CMD_SHORT_4 = 7'h0e;
    localparam logic [6:0] CMD_MOVE_CFG = 7'h2f;
    localparam logic [6:0] CMD_RAMP_HALT = 7'h0f;
    // ==========================================================
    // Frame constants
    localparam logic [5:0] ID_READ6 = 6'h3d;
    localparam logic [5:0] ID_DIAG = 6'h3c;
    localparam logic [7:0] APP_CMD_BYTE = 8'h80;
    localparam logic [7:0] SLEEP_BYTE = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic [3:0] LEN_BRIEF = 4'h2;
    localparam logic [3:0] LEN_POS = 4'h4;
    localparam logic [3:0] LEN_PREP7 = 4'h2;
    localparam logic [3:0] LEN_LONG = 4'h8;
    localparam logic [1:0] SIZE_POS = 2'b10;
    localparam logic [1:0] SIZE_BRIEF = 2'b00;
    // ==========================================================
    // Register offsets and reset values
    localparam logic [7:0] OFS_NODE = 8'h00;
    localparam logic [7:0] OFS_FUSE = 8'h04;
    localparam logic [7:0] OFS_IDMAP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [6:0] RST_NODE = 7'h00;
    localparam logic RST_SLEEP_PERMIT = 1'b0;
    localparam logic [5:0] RST_POS_ID = 6'h20;
    localparam logic [5:0] RST_BRIEF_ID = 6'h01;
    localparam int POS_ID_LSB = 0;
    localparam int BRIEF_ID_LSB = 8;
    localparam int SHORT_TGT_W = 11;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] pid;
        logic [3:0] len;
        logic [7:0][7:0] data;
    } lmcd_frame_t;
    typedef struct packed {
        logic end_switch_state;
        logic supply_reset_flag;
        logic missed_step_flag;
        logic electrical_fault_flag;
        logic undervoltage_flag;
        logic thermal_shutdown_flag;
        logic thermal_warning_flag;
        logic [1:0] thermal_band;
    } lmcd_state_t;
    typedef enum logic [3:0] {
        ACT_NONE, ACT_SAFE, ACT_HALT, ACT_ZERO, ACT_TWO_TARGET, ACT_MOTION_CFG,
        ACT_FUSE_PROG, ACT_STALL_CFG, ACT_ABS, ACT_SHORT, ACT_MOVE_CFG,
        ACT_RAMP, ACT_SLEEP, ACT_STOP
    } lmcd_action_t;
    typedef struct packed {
        lmcd_action_t action;
        logic [15:0] target;
        logic [7:0][7:0] args;
    } lmcd_motion_t;
    typedef struct packed {
        logic [3:0] len;
        logic [7:0][7:0] data;
        logic [7:0] checksum;
    } lmcd_resp_t;
endpackage

// [hw/lmcd_top.sv]
// Motor command decoder: frame decode, position read-back and APB registers
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module lmcd_top #(
    parameter logic [3:0] DEVICE_CODE = 4'h5 // Arbitrary identification value
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic rx_valid,
    input wire lmcd_pkg::lmcd_frame_t rx_frame,
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_pid,
    input wire logic [15:0] current_position,
    input wire lmcd_pkg::lmcd_state_t node_state,
    output logic resp_valid,
    output lmcd_pkg::lmcd_resp_t resp,
    output logic motion_valid,
    output lmcd_pkg::lmcd_motion_t motion
);
    // ==========================================================
    // Helpers
    // Protected identifier from a 6-bit frame identifier
    function automatic logic [7:0] prot_id(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    // Classic checksum: carry-folded sum, inverted
    function automatic logic [7:0] csum(input logic [7:0][7:0] d, input logic [3:0] n);
        logic [8:0] acc;
        acc = 9'h000;
        for (int i = 0; i < 8; i++)
        begin
            if (4'(i) < n)
            begin
                acc = {1'b0, acc[7:0]} + {1'b0, d[i]} + {8'h00, acc[8]};
            end
        end
        acc = {1'b0, acc[7:0]} + {8'h00, acc[8]};
        return ~acc[7:0];
    endfunction

    // Action for commands carried with a command byte (types 1, 3, 4)
    function automatic lmcd_pkg::lmcd_action_t act_of(input logic [6:0] c,
                                                      input logic wide);
        case (c)
            lmcd_pkg::CMD_GO_SAFE: return wide ? lmcd_pkg::ACT_NONE : lmcd_pkg::ACT_SAFE;
            lmcd_pkg::CMD_HALT: return wide ? lmcd_pkg::ACT_NONE : lmcd_pkg::ACT_HALT;
            lmcd_pkg::CMD_ZERO: return wide ? lmcd_pkg::ACT_NONE : lmcd_pkg::ACT_ZERO;
            lmcd_pkg::CMD_RAMP_HALT: return wide ? lmcd_pkg::ACT_NONE : lmcd_pkg::ACT_RAMP;
            lmcd_pkg::CMD_TWO_TARGET:
                return wide ? lmcd_pkg::ACT_TWO_TARGET : lmcd_pkg::ACT_NONE;
            lmcd_pkg::CMD_MOTION_CFG:
                return wide ? lmcd_pkg::ACT_MOTION_CFG : lmcd_pkg::ACT_NONE;
            lmcd_pkg::CMD_FUSE_PROG:
                return wide ? lmcd_pkg::ACT_FUSE_PROG : lmcd_pkg::ACT_NONE;
            lmcd_pkg::CMD_STALL_CFG:
                return wide ? lmcd_pkg::ACT_STALL_CFG : lmcd_pkg::ACT_NONE;
            lmcd_pkg::CMD_ABS_MOVE: return lmcd_pkg::ACT_ABS;
            default: return lmcd_pkg::ACT_NONE;
        endcase
    endfunction

    // ==========================================================
    // Registers
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [6:0] node_r;
    logic sleep_permit_r;
    logic [5:0] pos_id_r;
    logic [5:0] brief_id_r;
    logic pend_r;
    logic pend_nxt;
    logic [7:0] last_cmd_r;
    logic [7:0] perr_cnt_r;
    logic resp_valid_r;
    lmcd_pkg::lmcd_resp_t resp_r;
    logic motion_valid_r;
    lmcd_pkg::lmcd_motion_t motion_r;

    // ==========================================================
    // Received frame decode
    wire [5:0] rx_id = rx_frame.pid[5:0]; // Any identifier, dynamic ones included
    wire rx_par_ok = rx_frame.pid == prot_id(rx_id);
    wire rx_ok = rx_valid && rx_par_ok;
    wire diag_id = rx_id == lmcd_pkg::ID_DIAG;
    // Leading application byte shifts the payload by one (types 4 and 8)
    wire wide = rx_frame.len == lmcd_pkg::LEN_LONG &&
                rx_frame.data[0] == lmcd_pkg::APP_CMD_BYTE;
    wire [7:0] cmd_byte = wide ? rx_frame.data[1] : rx_frame.data[0];
    wire [7:0] addr_byte = wide ? rx_frame.data[2] : rx_frame.data[1];
    wire [15:0] abs_tgt = wide ? {rx_frame.data[3], rx_frame.data[4]}
                               : {rx_frame.data[2], rx_frame.data[3]};
    wire app_f = cmd_byte[7] && !(diag_id && rx_frame.data[0] == lmcd_pkg::SLEEP_BYTE);
    wire sleep_f = diag_id && rx_frame.data[0] == lmcd_pkg::SLEEP_BYTE;
    wire addr_hit = addr_byte[6:0] == node_r;
    // Broadcast bit low overrides the address compare
    wire write_hit = addr_hit || !addr_byte[7];
    wire read_hit = addr_byte[7] && addr_hit;
    wire lmcd_pkg::lmcd_action_t app_act = act_of(cmd_byte[6:0], wide);

    // Type 2 short frames: command byte has bit 7 clear, payload packed after it
    wire short_f = !diag_id && !rx_frame.data[0][7];
    wire [6:0] short_code = rx_frame.data[0][6:0];
    wire [55:0] short_p = rx_frame.data[7:1];
    wire short_hit = short_p[6:0] == node_r || !short_p[7];
    wire [1:0] slot = short_code == lmcd_pkg::CMD_SHORT_4 ? node_r[1:0] : {1'b0, node_r[0]};
    wire [5:0] slot_lsb = 6'(slot) * 6'd11;
    wire [10:0] grp_tgt = short_p[slot_lsb +: lmcd_pkg::SHORT_TGT_W];
    wire [10:0] one_tgt = short_p[18:8];
    wire grp_code = short_code == lmcd_pkg::CMD_SHORT_2 ||
                    short_code == lmcd_pkg::CMD_SHORT_4;
    wire one_code = short_code == lmcd_pkg::CMD_SHORT_1 ||
                    short_code == lmcd_pkg::CMD_MOVE_CFG;
    wire short_go = short_f && (grp_code || (one_code && short_hit));
    wire [10:0] short_tgt = grp_code ? grp_tgt : one_tgt;
    wire lmcd_pkg::lmcd_action_t short_act =
        short_code == lmcd_pkg::CMD_MOVE_CFG ? lmcd_pkg::ACT_MOVE_CFG
                                             : lmcd_pkg::ACT_SHORT;

    // Final action selection
    wire lmcd_pkg::lmcd_action_t sleep_act =
        sleep_permit_r ? lmcd_pkg::ACT_SLEEP : lmcd_pkg::ACT_STOP;
    wire app_go = app_f && write_hit && app_act != lmcd_pkg::ACT_NONE;
    wire motion_go = rx_ok && (sleep_f || app_go || short_go);
    wire lmcd_pkg::lmcd_action_t new_act = sleep_f ? sleep_act
                                         : app_go ? app_act : short_act;
    // Short targets are half-steps, sign-extended to the position width
    wire [15:0] new_tgt = app_go ? abs_tgt
                                 : {{5{short_tgt[10]}}, short_tgt};

    // Position read-back preparation (types 7 and 8)
    wire prep7 = rx_frame.len == lmcd_pkg::LEN_PREP7 && !rx_id[5];
    wire prep8 = wide && diag_id;
    wire prep_f = rx_ok && app_f && (prep7 || prep8) && read_hit;
    wire prep_pos = prep_f && cmd_byte[6:0] == lmcd_pkg::CMD_READ_POS;

    // ==========================================================
    // Header decode and responses
    wire hdr_ok = hdr_valid && hdr_pid == prot_id(hdr_pid[5:0]);
    wire [5:0] hdr_id = hdr_pid[5:0];
    wire pos_hdr = hdr_ok && hdr_id == pos_id_r && hdr_id[5:4] == lmcd_pkg::SIZE_POS;
    wire brief_hdr = hdr_ok && hdr_id == brief_id_r &&
                     hdr_id[5:4] == lmcd_pkg::SIZE_BRIEF;
    wire read6_hdr = hdr_ok && hdr_id == lmcd_pkg::ID_READ6 && pend_r;
    // Brief state byte is shared by every response that reports it
    wire [7:0] brief_flags = {node_state.supply_reset_flag, node_state.missed_step_flag,
                              node_state.electrical_fault_flag, node_state.undervoltage_flag,
                              node_state.thermal_shutdown_flag,
                              node_state.thermal_warning_flag, node_state.thermal_band};
    wire [7:0] id_byte = {node_state.end_switch_state, node_r};
    // Reads only sample the flags; nothing is cleared on this path
    wire [7:0][7:0] pos_data = {lmcd_pkg::FILL_BYTE, lmcd_pkg::FILL_BYTE,
                                lmcd_pkg::FILL_BYTE, {DEVICE_CODE, 4'h8},
                                brief_flags, current_position[7:0],
                                current_position[15:8], id_byte};
    wire [7:0][7:0] brief_data = {48'hffffffffffff, brief_flags, id_byte};
    wire [3:0] new_len = brief_hdr ? lmcd_pkg::LEN_BRIEF
                       : pos_hdr ? lmcd_pkg::LEN_POS : lmcd_pkg::LEN_LONG;
    wire [7:0][7:0] new_data = brief_hdr ? brief_data : pos_data;
    wire resp_go = pos_hdr || brief_hdr || read6_hdr;

    // Pending indirect read: a new prep wins over a read in the same cycle
    always_comb
    begin
        pend_nxt = pend_r;
        if (read6_hdr)
        begin
            pend_nxt = 1'b0;
        end
        if (prep_f)
        begin
            pend_nxt = prep_pos;
        end
    end

    // ==========================================================
    // Frame-side state
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pend_r <= 1'b0;
            resp_valid_r <= 1'b0;
            resp_r <= '0;
            motion_valid_r <= 1'b0;
            motion_r <= '0;
            last_cmd_r <= 8'h00;
            perr_cnt_r <= 8'h00;
        end
        else
        begin
            pend_r <= pend_nxt;
            resp_valid_r <= resp_go;
            if (resp_go)
            begin
                resp_r <= '{new_len, new_data, csum(new_data, new_len)};
            end
            motion_valid_r <= motion_go;
            if (motion_go)
            begin
                motion_r <= '{new_act, new_tgt, rx_frame.data};
                last_cmd_r <= {4'h0, new_act};
            end
            if (rx_valid && !rx_par_ok)
            begin
                perr_cnt_r <= perr_cnt_r + 8'h01; // Wraps; software takes deltas
            end
        end
    end

    // ==========================================================
    // APB slave: one wait state, registered answer
    wire apb_acc = psel && penable && !pready_r;
    wire apb_done = psel && penable && pready_r;
    wire a_node = paddr == lmcd_pkg::OFS_NODE;
    wire a_fuse = paddr == lmcd_pkg::OFS_FUSE;
    wire a_idmap = paddr == lmcd_pkg::OFS_IDMAP;
    wire a_stat = paddr == lmcd_pkg::OFS_STATUS;
    wire a_known = a_node || a_fuse || a_idmap || a_stat;
    wire [31:0] idmap_val = {18'h0, brief_id_r, 2'b00, pos_id_r};
    wire [31:0] rd_mux = a_node ? {25'h0, node_r}
                       : a_fuse ? {31'h0, sleep_permit_r}
                       : a_idmap ? idmap_val
                       : a_stat ? {15'h0, pend_r, perr_cnt_r, last_cmd_r} : 32'h0;
    wire wr_go = apb_done && pwrite;

    // Bus handshake and read data
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= apb_acc;
            prdata_r <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
            pslverr_r <= apb_acc && !a_known;
        end
    end

    // Writable registers; the fuse copy defaults to sleep disabled
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            node_r <= lmcd_pkg::RST_NODE;
            sleep_permit_r <= lmcd_pkg::RST_SLEEP_PERMIT;
            pos_id_r <= lmcd_pkg::RST_POS_ID;
            brief_id_r <= lmcd_pkg::RST_BRIEF_ID;
        end
        else if (wr_go)
        begin
            if (a_node)
            begin
                node_r <= pwdata[6:0];
            end
            if (a_fuse)
            begin
                sleep_permit_r <= pwdata[0];
            end
            if (a_idmap)
            begin
                pos_id_r <= pwdata[lmcd_pkg::POS_ID_LSB +: 6];
                brief_id_r <= pwdata[lmcd_pkg::BRIEF_ID_LSB +: 6];
            end
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign resp_valid = resp_valid_r;
    assign resp = resp_r;
    assign motion_valid = motion_valid_r;
    assign motion = motion_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    pos_len_a: assert property (pos_hdr |=> resp_valid && resp.len == lmcd_pkg::LEN_POS)
        else $error("direct position answer missing or wrong length");
    pos_value_a: assert property (pos_hdr |=>
        {resp.data[1], resp.data[2]} == $past(current_position))
        else $error("position bytes do not match");
    brief_same_a: assert property (pos_hdr |=> resp.data[3] == $past(brief_flags))
        else $error("position answer state byte differs");
    halt_decode_a: assert property (rx_ok && app_f && write_hit && !wide &&
        cmd_byte[6:0] == lmcd_pkg::CMD_HALT |=> motion_valid &&
        motion.action == lmcd_pkg::ACT_HALT)
        else $error("halt not decoded");
    ramp_a: assert property (rx_ok && app_f && write_hit && !wide &&
        cmd_byte[6:0] == lmcd_pkg::CMD_RAMP_HALT |=> motion.action == lmcd_pkg::ACT_RAMP)
        else $error("ramped halt not decoded");
    sleep_sel_a: assert property (rx_ok && sleep_f |=> motion_valid && motion.action ==
        ($past(sleep_permit_r) ? lmcd_pkg::ACT_SLEEP : lmcd_pkg::ACT_STOP))
        else $error("sleep selection wrong");
    parity_a: assert property (rx_valid && !rx_par_ok && !hdr_valid |=>
        !motion_valid && !resp_valid)
        else $error("bad parity frame acted upon");
    foreign_addr_a: assert property (rx_ok && !sleep_f && !short_f && addr_byte[7] &&
        !addr_hit |=> !motion_valid)
        else $error("foreign address acted upon");
    indirect_a: assert property (read6_hdr && !prep_f |=>
        resp_valid && resp.len == lmcd_pkg::LEN_LONG)
        else $error("indirect read not answered");
    abs_a: assert property (rx_ok && app_f && write_hit &&
        cmd_byte[6:0] == lmcd_pkg::CMD_ABS_MOVE |=> motion.target == $past(abs_tgt))
        else $error("absolute target wrong");

    pos_read_c: cover property (pos_hdr ##1 resp_valid);
    indirect_c: cover property (prep_pos ##[1:20] read6_hdr);
    bcast_c: cover property (rx_ok && app_go && !addr_hit);
    short_c: cover property (rx_ok && short_go && grp_code);
endmodule

// [verif/lmcd_master_model.sv]
// LIN master model: sends master frames and headers to the decoder
`timescale 1ns/1ps
module lmcd_master_model (
    input wire logic core_clk,
    output logic rx_valid,
    output lmcd_pkg::lmcd_frame_t rx_frame,
    output logic hdr_valid,
    output logic [7:0] hdr_pid
);
    // ==========================================================
    // Protected identifier with parity in bits 7:6
    function automatic logic [7:0] pid_of(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction
    // Quiet bus at time zero
    initial
    begin
        rx_valid = 1'b0;
        rx_frame = '0;
        hdr_valid = 1'b0;
        hdr_pid = 8'h00;
    end
    // Frame pulse; stale contents are scrambled so they cannot pass as fresh
    task automatic send(input logic [5:0] id, input logic [3:0] len, input logic [63:0] d);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_frame <= {pid_of(id), len, d};
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_frame <= ~{pid_of(id), len, d};
    endtask
    // Header only; the identifier always comes from the master
    task automatic header(input logic [5:0] id);
        @(posedge core_clk);
        hdr_valid <= 1'b1;
        hdr_pid <= pid_of(id);
        @(posedge core_clk);
        hdr_valid <= 1'b0;
        hdr_pid <= ~pid_of(id);
    endtask
    // Same frame with both parity bits flipped; the decoder must drop it
    task automatic send_bad(input logic [5:0] id, input logic [3:0] len, input logic [63:0] d);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_frame <= {pid_of(id) ^ 8'hc0, len, d};
        @(posedge core_clk);
        rx_valid <= 1'b0;
    endtask
endmodule

// [verif/lmcd_top_tb.sv]
// Self-checking testbench for the motor command decoder
`timescale 1ns/1ps
module lmcd_top_tb;
    localparam logic [3:0] DEV = 4'h9; // Arbitrary identification value
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, rx_valid, hdr_valid, resp_valid, motion_valid;
    logic [31:0] prdata;
    logic [7:0] hdr_pid;
    logic [15:0] current_position = 16'h0;
    lmcd_pkg::lmcd_state_t node_state = '0;
    lmcd_pkg::lmcd_frame_t rx_frame;
    lmcd_pkg::lmcd_resp_t resp;
    lmcd_pkg::lmcd_motion_t motion, mot_seen;
    logic [6:0] node;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [32:0] q_apb[$];
    lmcd_pkg::lmcd_resp_t q_resp[$];
    lmcd_pkg::lmcd_motion_t q_mot[$];
    logic q_tgt[$];
    logic [6:0] codes[10] = '{7'h04, 7'h05, 7'h06, 7'h0f, 7'h0b, 7'h08, 7'h09, 7'h10, 7'h16, 7'h0b};
    lmcd_pkg::lmcd_action_t acts[10] = '{lmcd_pkg::ACT_SAFE, lmcd_pkg::ACT_HALT,
        lmcd_pkg::ACT_ZERO, lmcd_pkg::ACT_RAMP, lmcd_pkg::ACT_ABS, lmcd_pkg::ACT_TWO_TARGET,
        lmcd_pkg::ACT_MOTION_CFG, lmcd_pkg::ACT_FUSE_PROG, lmcd_pkg::ACT_STALL_CFG,
        lmcd_pkg::ACT_ABS};
    // ==========================================================
    // Clock, design and master model
    always #5 core_clk = ~core_clk;
    lmcd_top #(.DEVICE_CODE(DEV)) u_lmcd_top (.core_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .rx_valid, .rx_frame, .hdr_valid,
        .hdr_pid, .current_position, .node_state, .resp_valid, .resp, .motion_valid, .motion);
    lmcd_master_model u_lmcd_master_model (.core_clk, .rx_valid, .rx_frame, .hdr_valid,
        .hdr_pid);
    // Verdict and run end
    task automatic summarize;
        $display("Checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Unused response bytes are not part of the answer
    function automatic lmcd_pkg::lmcd_resp_t masked(input lmcd_pkg::lmcd_resp_t r);
        for (int i = 0; i < 8; i++)
            if (i >= r.len) r.data[i] = 8'h00;
        return r;
    endfunction
    // Classic checksum: carry folded back, then inverted
    function automatic lmcd_pkg::lmcd_resp_t mk_resp(input logic [3:0] n, input logic [63:0] d);
        lmcd_pkg::lmcd_resp_t r;
        logic [8:0] s;
        r = masked('{n, d, 8'h00});
        s = 9'h0;
        for (int i = 0; i < n; i++)
        begin
            s = 9'(s[7:0]) + 9'(r.data[i]);
            s = 9'(s[7:0]) + 9'(s[8]);
        end
        r.checksum = ~s[7:0];
        return r;
    endfunction
    // APB master: setup, then access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] exp);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        q_apb.push_back(exp);
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Header read with fresh position and state; n of 0 expects silence
    task automatic header_read(input logic [5:0] id, input logic [3:0] n);
        logic [15:0] p;
        lmcd_pkg::lmcd_state_t s;
        p = 16'($urandom()); // All bits compared; masking is left to the master
        s = 9'($urandom());
        current_position <= p;
        node_state <= s;
        if (n == 4'h2)
            q_resp.push_back(mk_resp(n, {48'h0, s[7:0], s[8], node}));
        else if (n != 4'h0)
            q_resp.push_back(mk_resp(n, {24'hffffff, DEV, 4'h8, s[7:0], p[7:0], p[15:8],
                s[8], node}));
        u_lmcd_master_model.header(id);
    endtask
    task automatic note_mot(input lmcd_pkg::lmcd_action_t a, input logic [15:0] t,
            input logic [63:0] d, input logic tg);
        q_mot.push_back('{a, tg ? t : 16'h0, d});
        q_tgt.push_back(tg);
    endtask
    // Write frame, narrow (len 4) or wide (len 8 with leading command byte)
    task automatic wr_cmd(input logic wide, input logic [6:0] cmd, input logic bn,
            input logic [6:0] adr, input lmcd_pkg::lmcd_action_t a, input logic hit);
        logic [63:0] d;
        logic [15:0] t;
        t = 16'($urandom());
        d = '1;
        if (wide)
            d[39:0] = {t[7:0], t[15:8], bn, adr, 1'b1, cmd, 8'h80};
        else
            d[31:0] = {t[7:0], t[15:8], bn, adr, 1'b1, cmd};
        if (hit)
            note_mot(a, t, d, a == lmcd_pkg::ACT_ABS);
        u_lmcd_master_model.send(wide ? 6'h38 : 6'h28, wide ? 4'h8 : 4'h4, d);
    endtask
    // Type 2 move; b is the bit offset of this node's 11-bit target
    task automatic short_cmd(input logic [6:0] cmd, input lmcd_pkg::lmcd_action_t a, input int b);
        logic [55:0] p;
        logic [10:0] t;
        p = {$urandom(), 24'($urandom())};
        if (b == 8)
            p[7:0] = {1'b1, node};
        t = p[b+:11];
        note_mot(a, {{5{t[10]}}, t}, {p, 1'b0, cmd}, 1'b1);
        u_lmcd_master_model.send(6'h38, 4'h8, {p, 1'b0, cmd});
    endtask
    task automatic sleep_cmd(input lmcd_pkg::lmcd_action_t a);
        note_mot(a, 16'h0, {{7{8'hff}}, 8'h00}, 1'b0);
        u_lmcd_master_model.send(6'h3c, 4'h8, {{7{8'hff}}, 8'h00});
    endtask
    // ==========================================================
    // Watcher: each answer retires the oldest note of its kind; also the hang guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (!rst && pready === 1'b1)
            chk(128'({pslverr, prdata}), 128'(q_apb.size() ? q_apb.pop_front() : 'x));
        if (!rst && resp_valid === 1'b1)
            chk(128'(masked(resp)), 128'(q_resp.size() ? q_resp.pop_front() : 'x));
        if (!rst && motion_valid === 1'b1)
        begin
            mot_seen = motion;
            if (q_tgt.size() && q_tgt.pop_front() == 1'b0)
                mot_seen.target = 16'h0;
            chk(128'(mot_seen), 128'(q_mot.size() ? q_mot.pop_front() : 'x));
        end
        // Hang guard last, so nothing runs after the verdict
        if (cycles == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    // Main sequence: registers, reads, writes, sleep
    initial
    begin
        void'($urandom(32'hd40fba5d));
        node = 7'($urandom());
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0, {26'h0, lmcd_pkg::RST_NODE});
        apb(1'b0, 8'h04, 32'h0, {32'h0, lmcd_pkg::RST_SLEEP_PERMIT});
        apb(1'b0, 8'h08, 32'h0, {19'h0, lmcd_pkg::RST_BRIEF_ID, 2'b00, lmcd_pkg::RST_POS_ID});
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h10, 32'h1, {1'b1, 32'h0});
        apb(1'b1, 8'h00, {25'h0, node}, 33'h0);
        apb(1'b0, 8'h00, 32'h0, {26'h0, node});
        header_read(6'h20, 4'h4);
        header_read(6'h01, 4'h2);
        u_lmcd_master_model.send(6'h10, 4'h2, {48'hffffffffffff, 1'b1, node, 8'h80});
        header_read(6'h3d, 4'h8);
        u_lmcd_master_model.send(6'h3c, 4'h8, {40'hffffffffff, 1'b1, node, 16'h8080});
        header_read(6'h3d, 4'h8);
        header_read(6'h3d, 4'h0);
        for (int i = 0; i < 10; i++)
            wr_cmd(i > 4, codes[i], 1'b1, node, acts[i], 1'b1);
        wr_cmd(1'b1, 7'h05, 1'b1, node, lmcd_pkg::ACT_HALT, 1'b0);
        wr_cmd(1'b0, 7'h08, 1'b1, node, lmcd_pkg::ACT_TWO_TARGET, 1'b0);
        wr_cmd(1'b0, 7'h0b, 1'b1, node ^ 7'h01, lmcd_pkg::ACT_ABS, 1'b0);
        wr_cmd(1'b1, 7'h0b, 1'b0, node ^ 7'h01, lmcd_pkg::ACT_ABS, 1'b1);
        // Addressed halt with corrupted parity: no motion, one parity error counted
        u_lmcd_master_model.send_bad(6'h28, 4'h4, {48'hffffffffffff, 1'b1, node, 8'h85});
        short_cmd(7'h0c, lmcd_pkg::ACT_SHORT, 8);
        short_cmd(7'h2f, lmcd_pkg::ACT_MOVE_CFG, 8);
        short_cmd(7'h0d, lmcd_pkg::ACT_SHORT, 11 * int'(node[0]));
        short_cmd(7'h0e, lmcd_pkg::ACT_SHORT, 11 * int'(node[1:0]));
        sleep_cmd(lmcd_pkg::ACT_STOP);
        apb(1'b1, 8'h04, 32'h1, 33'h0);
        sleep_cmd(lmcd_pkg::ACT_SLEEP);
        // Status: no read pending, one parity error, last action was sleep
        apb(1'b0, 8'h0c, 32'h0, {17'h0, 8'h01, 4'h0, lmcd_pkg::ACT_SLEEP});
        repeat (5) @(posedge core_clk);
        chk(128'(q_apb.size() + q_resp.size() + q_mot.size()), 128'h0);
        summarize();
    end
endmodule
